/* emb_pkg.sv */
// Constants shared by the external memory bus configuration block.
package emb_pkg;

  // Address width select codes.
  localparam logic [1:0] EMB_ABW_20    = 2'h0;
  localparam logic [1:0] EMB_ABW_16    = 2'h1;
  localparam logic [1:0] EMB_ABW_12    = 2'h2;
  localparam logic [1:0] EMB_ABW_MCU   = 2'h3;

  // Bus control register layout and reset value.
  localparam int         EMB_CTRL_RELEASE_POS = 7;
  localparam int         EMB_CTRL_WAIT_LSB    = 4;
  localparam logic [7:0] EMB_CTRL_RST         = 8'h00;
  localparam logic [7:0] EMB_CTRL_WMASK       = 8'hb0;

  // Pad configuration one: pull-up field position and reset value.
  localparam int         EMB_PAD_PU_LSB = 5;
  localparam logic [2:0] EMB_PAD_PU_RST = 3'h0;

  // Address line masks per address width.
  localparam logic [19:0] EMB_MASK_20 = 20'hfffff;
  localparam logic [19:0] EMB_MASK_16 = 20'h0ffff;
  localparam logic [19:0] EMB_MASK_12 = 20'h00fff;

  // Timing: one wait unit is one instruction cycle.
  localparam int         EMB_CLK_NS     = 50;
  localparam int         EMB_TCY_NS     = 50;
  localparam int         EMB_TCY_CYCLES = (EMB_TCY_NS + EMB_CLK_NS - 1) / EMB_CLK_NS;

  typedef enum logic [2:0] {
    EMB_IDLE = 3'h0,
    EMB_ADDR = 3'h1,
    EMB_DATA = 3'h3,
    EMB_WAIT = 3'h2,
    EMB_SYNC = 3'h6,
    EMB_DONE = 3'h7
  } emb_state_t;

endpackage

/* emb_wait_if.sv */
// Handshake between the bus sequencer and its wait-state counter.
`timescale 1ns/1ps
`default_nettype none
interface emb_wait_if;
  logic       start;
  logic [3:0] cycles;
  logic       done;
  modport seq (output start, output cycles, input done);
  modport ctr (input start, input cycles, output done);
endinterface
`default_nettype wire

/* emb_wait_ctr.sv */
// Wait-state down counter loaded in the data phase of a table operation.
`timescale 1ns/1ps
`default_nettype none
module emb_wait_ctr (
  input  wire logic clock,  // Instruction clock.
  input  wire logic rst_n,  // Asynchronous reset, active low.
  emb_wait_if.ctr   w       // Start, length and done.
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (w.start) begin
      cnt_d = w.cycles;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Done marks the last wait cycle, or no wait at all.
  assign w.done = (cnt_q <= 4'h1);

endmodule // emb_wait_ctr
`default_nettype wire

/* emb_bus_cfg.sv */
// External multiplexed memory bus: width configuration, address mapping and wait states.
`timescale 1ns/1ps
`default_nettype none
module emb_bus_cfg
  import emb_pkg::*;
#(
  parameter logic [20:0] ONCHIP_BYTES = 21'h020000  // On-chip program memory size.
) (
  input  wire logic        clock,                // Instruction clock, 20 MHz.
  input  wire logic        rst_n,                // Asynchronous reset, active low.
  input  wire logic        data_width_select,    // Strap: 1 = 16-bit data.
  input  wire logic [1:0]  address_width_select, // Strap: address width code.
  input  wire logic        address_shift_enable, // Strap: subtract on-chip size.
  input  wire logic        wait_enable,          // Strap: allow wait states.
  input  wire logic        ctrl_we,              // Bus control register write strobe.
  input  wire logic [7:0]  ctrl_wdata,           // Bus control register write data.
  output logic [7:0]       ctrl_rdata,           // Bus control register contents.
  input  wire logic        byte_select_mode,     // 16-bit byte select mode active.
  input  wire logic        pad_we,               // Pad config one write strobe.
  input  wire logic [7:0]  pad_wdata,            // Pad config one write data.
  output logic             low_data_port_pullup, // Pull-ups on low data port.
  output logic             high_data_port_pullup,// Pull-ups on high data port.
  output logic             control_port_pullup,  // Pull-ups on control port.
  input  wire logic        req_valid,            // Access request.
  output logic             req_ready,            // Request accepted this cycle.
  input  wire logic        req_write,            // 1 = table write.
  input  wire logic [20:0] req_addr,             // Byte address from program counter.
  input  wire logic [15:0] req_wdata,            // Write data.
  output logic             rsp_valid,            // Access finished, one-cycle pulse.
  output logic [15:0]      rsp_rdata,            // Read data.
  output logic [15:0]      ad_out,               // Multiplexed lines output.
  output logic [15:0]      ad_oe_n,              // Multiplexed lines enable, low drives.
  input  wire logic [15:0] ad_in,                // Multiplexed lines input.
  output logic [3:0]       a_hi_out,             // Address-only top lines.
  output logic [3:0]       a_hi_oe_n,            // Top lines enable, low drives.
  output logic [19:0]      bus_owns_line,        // Line taken from port I/O.
  output logic             bus_owns_ctl,         // Control pins taken from port I/O.
  output logic             ale,                  // Address latch enable.
  output logic             oe_n,                 // Output enable, active low.
  output logic             wr_n,                 // Write strobe, active low.
  output logic             ce_n,                 // Chip enable, active low.
  output logic             byte_address_lsb,     // Byte address line.
  output logic             upper_byte_enable_n,  // Upper byte enable.
  output logic             lower_byte_enable_n   // Lower byte enable.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [19:0] addr_mask(input logic [1:0] abw);
    logic [19:0] m;
    m = 20'h00000;
    if (abw == EMB_ABW_20) begin
      m = EMB_MASK_20;
    end else if (abw == EMB_ABW_16) begin
      m = EMB_MASK_16;
    end else if (abw == EMB_ABW_12) begin
      m = EMB_MASK_12;
    end
    return m;
  endfunction

  // Field 11 -> 0, 10 -> 1, 01 -> 2, 00 -> 3 instruction cycles.
  function automatic logic [1:0] wait_tcy(input logic [1:0] code);
    return ~code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture: taken once after reset and never changed by software.

  logic       cfg_loaded_q, cfg_loaded_d;
  logic       dw16_q, dw16_d;
  logic [1:0] abw_q, abw_d;
  logic       shift_q, shift_d;
  logic       wait_en_q, wait_en_d;

  always_comb begin
    cfg_loaded_d = 1'b1;
    dw16_d       = dw16_q;
    abw_d        = abw_q;
    shift_d      = shift_q;
    wait_en_d    = wait_en_q;
    if (!cfg_loaded_q) begin
      dw16_d    = data_width_select;
      abw_d     = address_width_select;
      shift_d   = address_shift_enable;
      wait_en_d = wait_enable;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_loaded_q <= 1'b0;
      dw16_q       <= 1'b1;
      abw_q        <= EMB_ABW_MCU;
      shift_q      <= 1'b0;
      wait_en_q    <= 1'b0;
    end else begin
      cfg_loaded_q <= cfg_loaded_d;
      dw16_q       <= dw16_d;
      abw_q        <= abw_d;
      shift_q      <= shift_d;
      wait_en_q    <= wait_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus control and pad registers.

  logic [7:0] ctrl_q, ctrl_d;
  logic [2:0] pu_q, pu_d;
  logic       mcu_mode;

  assign mcu_mode = (abw_q == EMB_ABW_MCU);

  always_comb begin
    ctrl_d = ctrl_q;
    pu_d   = pu_q;
    if (ctrl_we && !mcu_mode) begin
      ctrl_d = ctrl_wdata & EMB_CTRL_WMASK;
    end
    if (pad_we) begin
      pu_d = pad_wdata[EMB_PAD_PU_LSB +: 3];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= EMB_CTRL_RST;
      pu_q   <= EMB_PAD_PU_RST;
    end else begin
      ctrl_q <= ctrl_d;
      pu_q   <= pu_d;
    end
  end

  assign ctrl_rdata            = ctrl_q;
  assign low_data_port_pullup  = pu_q[0];
  assign high_data_port_pullup = pu_q[1];
  assign control_port_pullup   = pu_q[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser.

  logic [15:0] ad_s1_q;
  logic [15:0] ad_s2_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ad_s1_q <= 16'h0000;
      ad_s2_q <= 16'h0000;
    end else begin
      ad_s1_q <= ad_in;
      ad_s2_q <= ad_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address mapping.

  logic [20:0] ext_addr;
  logic        byte_mode21;
  logic [19:0] line_addr;
  logic [19:0] amask;
  logic [15:0] dmask;
  logic [3:0]  wait_cycles;

  assign amask = addr_mask(abw_q);
  // Data lines: low eight, or sixteen limited by the address width.
  assign dmask = dw16_q ? amask[15:0] : 16'h00ff;
  assign ext_addr = shift_q ? (req_addr - ONCHIP_BYTES) : req_addr;
  assign byte_mode21 = (abw_q == EMB_ABW_20) && (!dw16_q || byte_select_mode);
  assign line_addr = byte_mode21 ? ext_addr[20:1] : ext_addr[19:0];
  assign wait_cycles = wait_en_q ?
    4'(wait_tcy(ctrl_q[EMB_CTRL_WAIT_LSB +: 2]) * EMB_TCY_CYCLES) : 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  emb_wait_if w ();

  emb_wait_ctr u_wait (
    .clock (clock),
    .rst_n (rst_n),
    .w     (w)
  );

  emb_state_t  st_q, st_d;
  logic        wr_q, wr_d;
  logic [19:0] la_q, la_d;
  logic        ba_q, ba_d;
  logic [15:0] wd_q, wd_d;
  logic [3:0]  wc_q, wc_d;
  logic [15:0] rd_q, rd_d;
  logic        rsp_q, rsp_d;

  assign req_ready = (st_q == EMB_IDLE) && cfg_loaded_q && !mcu_mode;
  assign w.start   = (st_q == EMB_DATA);
  assign w.cycles  = wc_q;

  always_comb begin
    st_d  = st_q;
    wr_d  = wr_q;
    la_d  = la_q;
    ba_d  = ba_q;
    wd_d  = wd_q;
    wc_d  = wc_q;
    rd_d  = rd_q;
    rsp_d = 1'b0;
    case (st_q)
      EMB_IDLE: begin
        if (req_valid && req_ready) begin
          wr_d = req_write;
          la_d = line_addr & amask;
          ba_d = byte_mode21 & ext_addr[0];
          wd_d = req_wdata;
          wc_d = wait_cycles;
          st_d = EMB_ADDR;
        end
      end
      EMB_ADDR: begin
        st_d = EMB_DATA;
      end
      EMB_DATA: begin
        if (wc_q != 4'h0) begin
          st_d = EMB_WAIT;
        end else if (wr_q) begin
          st_d = EMB_DONE;
        end else begin
          st_d = EMB_SYNC;
        end
      end
      EMB_WAIT: begin
        if (w.done) begin
          st_d = wr_q ? EMB_DONE : EMB_SYNC;
        end
      end
      EMB_SYNC: begin
        st_d = EMB_DONE;
      end
      EMB_DONE: begin
        if (!wr_q) begin
          rd_d = ad_s2_q & dmask;
        end
        rsp_d = 1'b1;
        st_d  = EMB_IDLE;
      end
      default: begin
        st_d = EMB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= EMB_IDLE;
      wr_q  <= 1'b0;
      la_q  <= 20'h00000;
      ba_q  <= 1'b0;
      wd_q  <= 16'h0000;
      wc_q  <= 4'h0;
      rd_q  <= 16'h0000;
      rsp_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      wr_q  <= wr_d;
      la_q  <= la_d;
      ba_q  <= ba_d;
      wd_q  <= wd_d;
      wc_q  <= wc_d;
      rd_q  <= rd_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp_valid = rsp_q;
  assign rsp_rdata = rd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive, registered from the next state.

  logic [15:0] ad_q, ad_d, adoe_q, adoe_d;
  logic [3:0]  ahi_q, ahi_d, ahioe_q, ahioe_d;
  logic [19:0] own_q, own_d;
  logic        ownc_q, ownc_d;
  logic        ale_q, ale_d, oe_q, oe_d, wrn_q, wrn_d, ce_q, ce_d;
  logic        ba0_q, ba0_d, ub_q, ub_d, lb_q, lb_d;
  logic        active;

  always_comb begin
    active  = (st_d != EMB_IDLE);
    // Release clear keeps the pins on the bus; set frees them between accesses.
    ownc_d  = !mcu_mode && (!ctrl_q[EMB_CTRL_RELEASE_POS] || active);
    own_d   = ownc_d ? amask : 20'h00000;
    ad_d    = 16'h0000;
    adoe_d  = 16'hffff;
    ahi_d   = 4'h0;
    ahioe_d = 4'hf;
    ale_d   = 1'b0;
    oe_d    = 1'b1;
    wrn_d   = 1'b1;
    ce_d    = !active;
    ba0_d   = 1'b0;
    ub_d    = 1'b1;
    lb_d    = 1'b1;
    if (active) begin
      ahi_d   = la_d[19:16];
      ahioe_d = ~amask[19:16];
      ba0_d   = ba_d;
      if (st_d == EMB_ADDR) begin
        ad_d   = la_d[15:0];
        adoe_d = ~amask[15:0];
        ale_d  = 1'b1;
      end else begin
        // Address-only lines keep the address while data lines turn.
        ad_d   = la_d[15:0] & ~dmask;
        adoe_d = ~(amask[15:0] & ~dmask);
        if (wr_d) begin
          ad_d   = ad_d | (dw16_q ? wd_d : {8'h00, wd_d[7:0]}) & dmask;
          adoe_d = adoe_d & ~dmask;
          wrn_d  = (st_d == EMB_DONE);
        end else begin
          oe_d = 1'b0;
        end
        if (dw16_q && byte_select_mode) begin
          ub_d = !ba_d;
          lb_d = ba_d;
        end else begin
          ub_d = 1'b0;
          lb_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ad_q    <= 16'h0000;
      adoe_q  <= 16'hffff;
      ahi_q   <= 4'h0;
      ahioe_q <= 4'hf;
      own_q   <= 20'h00000;
      ownc_q  <= 1'b0;
      ale_q   <= 1'b0;
      oe_q    <= 1'b1;
      wrn_q   <= 1'b1;
      ce_q    <= 1'b1;
      ba0_q   <= 1'b0;
      ub_q    <= 1'b1;
      lb_q    <= 1'b1;
    end else begin
      ad_q    <= ad_d;
      adoe_q  <= adoe_d;
      ahi_q   <= ahi_d;
      ahioe_q <= ahioe_d;
      own_q   <= own_d;
      ownc_q  <= ownc_d;
      ale_q   <= ale_d;
      oe_q    <= oe_d;
      wrn_q   <= wrn_d;
      ce_q    <= ce_d;
      ba0_q   <= ba0_d;
      ub_q    <= ub_d;
      lb_q    <= lb_d;
    end
  end

  assign ad_out              = ad_q;
  assign ad_oe_n             = adoe_q;
  assign a_hi_out            = ahi_q;
  assign a_hi_oe_n           = ahioe_q;
  assign bus_owns_line       = own_q;
  assign bus_owns_ctl        = ownc_q;
  assign ale                 = ale_q;
  assign oe_n                = oe_q;
  assign wr_n                = wrn_q;
  assign ce_n                = ce_q;
  assign byte_address_lsb    = ba0_q;
  assign upper_byte_enable_n = ub_q;
  assign lower_byte_enable_n = lb_q;

endmodule // emb_bus_cfg
`default_nettype wire

/* emb_bus_cfg_assertions.sv */
// Port checks for the external memory bus configuration block.
`timescale 1ns/1ps
`default_nettype none
module emb_bus_cfg_chk
  import emb_pkg::*;
(
  input wire logic        clock,                // Clock.
  input wire logic        rst_n,                // Reset.
  input wire logic        data_width_select,    // Strap.
  input wire logic [1:0]  address_width_select, // Strap.
  input wire logic        wait_enable,          // Strap.
  input wire logic [7:0]  ctrl_rdata,           // Control.
  input wire logic        byte_select_mode,     // Mode.
  input wire logic        req_valid,            // Request.
  input wire logic        req_ready,            // Ready.
  input wire logic        req_write,            // Write.
  input wire logic        rsp_valid,            // Done.
  input wire logic [15:0] ad_oe_n,              // Enables.
  input wire logic [19:0] bus_owns_line,        // Owned.
  input wire logic        ale,                  // Strobe.
  input wire logic        oe_n,                 // Read.
  input wire logic        wr_n,                 // Write.
  input wire logic        byte_address_lsb,     // Byte line.
  input wire logic        upper_byte_enable_n,  // Upper.
  input wire logic        lower_byte_enable_n   // Lower.
);
  logic [1:0]  abw;
  logic [1:0]  nw;
  logic        fire;
  logic [19:0] amask;
  assign abw = address_width_select;
  assign nw = wait_enable ? ~ctrl_rdata[5:4] : 2'h0;
  assign fire = req_valid && req_ready;
  assign amask = abw == EMB_ABW_20 ? EMB_MASK_20 : abw == EMB_ABW_16 ? EMB_MASK_16 : EMB_MASK_12;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_hi_lines_free: assert property (abw != EMB_ABW_20 |-> bus_owns_line[19:16] == 4'h0)
    else $error("top lines taken by bus");
  a_top_data_hidden: assert property (abw == EMB_ABW_12 |-> ad_oe_n[15:12] == 4'hf)
    else $error("hidden data bits driven");
  a_addr_then_data: assert property ($rose(ale) |=> !ale && (!oe_n || !wr_n))
    else $error("data phase missing after address");
  a_write_nowait: assert property (fire && req_write && nw == 2'h0 |-> ##1 !rsp_valid[*3] ##1 rsp_valid)
    else $error("write length wrong");
  a_read_nowait: assert property (fire && !req_write && nw == 2'h0 |-> ##1 !rsp_valid[*4] ##1 rsp_valid)
    else $error("read length wrong");
  a_wait_bound: assert property (fire |-> ##[4:8] rsp_valid)
    else $error("access too long");
  a_bus_off: assert property (abw == EMB_ABW_MCU |-> !req_ready && bus_owns_line == 20'h0)
    else $error("disabled bus active");
  a_owned_idle: assert property (!ctrl_rdata[7] && !$past(ctrl_rdata[7]) && $past(rst_n, 3) && abw != EMB_ABW_MCU |-> bus_owns_line == amask)
    else $error("bus ownership wrong");
  a_byte_pick: assert property (data_width_select && byte_select_mode && (!oe_n || !wr_n) |-> upper_byte_enable_n != lower_byte_enable_n)
    else $error("byte enables not exclusive");
  a_ba_zero: assert property (!(abw == EMB_ABW_20 && (!data_width_select || byte_select_mode)) |-> !byte_address_lsb)
    else $error("byte line used outside byte modes");
endmodule // emb_bus_cfg_chk
bind emb_bus_cfg emb_bus_cfg_chk u_chk (
  .clock, .rst_n, .data_width_select, .address_width_select, .wait_enable, .ctrl_rdata,
  .byte_select_mode, .req_valid, .req_ready, .req_write, .rsp_valid, .ad_oe_n,
  .bus_owns_line, .ale, .oe_n, .wr_n, .byte_address_lsb, .upper_byte_enable_n,
  .lower_byte_enable_n
);
`default_nettype wire

/* emb_mem_model.sv */
// Behavioural external memory on the multiplexed bus.
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  input  wire logic        clock,            // Bench clock.
  input  wire logic        ale,              // Address strobe.
  input  wire logic        oe_n,             // Read enable.
  input  wire logic        wr_n,             // Write strobe.
  input  wire logic [15:0] ad_out,           // Lines in.
  input  wire logic [3:0]  a_hi_out,         // Top lines.
  input  wire logic        byte_address_lsb, // Byte line.
  output var logic  [15:0] ad_in,            // Lines out.
  output var logic  [20:0] last_addr         // Latched address.
);
  logic [15:0] mem [int];
  logic [15:0] last_q = 16'h0000;
  // Strobes and lines change on the same rising edge, so the bus is sampled mid-cycle.
  always @(negedge clock) begin
    if (ale === 1'b1)
      last_addr = {a_hi_out, ad_out, byte_address_lsb};
    if (wr_n === 1'b0 && !$isunknown(last_addr)) begin
      mem[last_addr] = ad_out;
      last_q = ad_out;
    end
  end
  // Released lines show the inverse of the last word, never a stale copy.
  always @* begin
    if (!oe_n && mem.exists(last_addr))
      ad_in = mem[last_addr];
    else
      ad_in = ~last_q;
  end
endmodule // emb_mem_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the external memory bus configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import emb_pkg::*;
  localparam logic [20:0] ONCHIP = 21'h020000;
  logic        clock, rst_n, dw, sh, wen, cwe, bsm, pwe, rv, rw, b21;
  logic        rdy, rsv, lpu, hpu, cpu, ale, oe_n, wr_n, ba;
  logic [1:0]  abw;
  logic [7:0]  cwd, pwd, crd;
  logic [20:0] ra, madr, a, e;
  logic [15:0] wd, rd, ado, adi, dm;
  logic [3:0]  aho, ahoe;
  logic        oc, cen;
  logic [19:0] own, m;
  logic [31:0] x;
  logic [15:0] ref_m [int];
  logic [5:0]  cfg [8] = '{6'h22, 6'h06, 6'h2c, 6'h32, 6'h12, 6'h23, 6'h08, 6'h3a};
  int          n_fail = 0, n_tests = 0, seed = 75134, cyc = 0, n;

  emb_bus_cfg #(.ONCHIP_BYTES(ONCHIP)) uut (
    .clock(clock), .rst_n(rst_n), .data_width_select(dw), .address_width_select(abw),
    .address_shift_enable(sh), .wait_enable(wen), .ctrl_we(cwe), .ctrl_wdata(cwd),
    .ctrl_rdata(crd), .byte_select_mode(bsm), .pad_we(pwe), .pad_wdata(pwd),
    .low_data_port_pullup(lpu), .high_data_port_pullup(hpu), .control_port_pullup(cpu),
    .req_valid(rv), .req_ready(rdy), .req_write(rw), .req_addr(ra), .req_wdata(wd),
    .rsp_valid(rsv), .rsp_rdata(rd), .ad_out(ado), .ad_oe_n(), .ad_in(adi),
    .a_hi_out(aho), .a_hi_oe_n(ahoe), .bus_owns_line(own), .bus_owns_ctl(oc), .ale(ale),
    .oe_n(oe_n), .wr_n(wr_n), .ce_n(cen), .byte_address_lsb(ba),
    .upper_byte_enable_n(), .lower_byte_enable_n()
  );
  emb_mem_model u_mem (
    .clock(clock), .ale(ale), .oe_n(oe_n), .wr_n(wr_n), .ad_out(ado), .a_hi_out(aho),
    .byte_address_lsb(ba), .ad_in(adi), .last_addr(madr)
  );
  ////////////////////////////////////////
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task do_reset(input logic [5:0] c);
    rst_n = 0;
    {dw, abw, sh, wen, bsm} = c;
    repeat (12) @(negedge clock);
    rst_n = 1;
    @(negedge clock);
    chk({lpu, hpu, cpu, crd}, 0);
    @(negedge clock);
  endtask
  // One table access; the request is held until the edge that takes it.
  task acc(input logic w, input logic [15:0] d);
    int k;
    k = 0;
    rv = 1;
    rw = w;
    ra = a;
    wd = d;
    while (rdy !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    rv = 0;
    chk(rdy, 0);
    chk({cen, ale}, 2'h1);
    k = 0;
    while (rsv !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    chk(k, (w ? 3 : 4) + n);
    chk(madr, e);
  endtask
  ////////////////////////////////////////
  initial begin
    {rst_n, dw, abw, sh, wen, cwe, bsm, pwe, rv, rw} = 0;
    {cwd, pwd, ra, wd} = 0;
    foreach (cfg[i]) begin
      do_reset(cfg[i]);
      m = abw == EMB_ABW_20 ? EMB_MASK_20 : abw == EMB_ABW_16 ? EMB_MASK_16 : EMB_MASK_12;
      m = abw == EMB_ABW_MCU ? 20'h0 : m;
      dm = !dw ? 16'h00ff : abw == EMB_ABW_12 ? 16'h0fff : 16'hffff;
      b21 = abw == EMB_ABW_20 && (!dw || bsm);
      chk(own, m);
      for (int c = 0; c < 4; c++) begin
        x = $random(seed);
        cwd = {x[7:6], c[1:0], x[3:0]};
        pwd = x[15:8];
        cwe = 1;
        pwe = 1;
        @(negedge clock);
        cwe = 0;
        pwe = 0;
        chk(crd, abw == EMB_ABW_MCU ? 8'h00 : cwd & EMB_CTRL_WMASK);
        chk({cpu, hpu, lpu}, pwd[7:5]);
        @(negedge clock);
        @(negedge clock);
        chk(own, crd[7] ? 20'h0 : m);
        chk({oc, cen, ahoe}, {(abw != EMB_ABW_MCU) && !crd[7], 1'b1, 4'hf});
        if (abw == EMB_ABW_MCU) begin
          rv = 1;
          repeat (4) @(negedge clock);
          chk(rdy, 0);
          rv = 0;
        end else begin
          a = ONCHIP + {1'b0, x[31:12]};
          n = wen ? 3 - c : 0;
          e = a - (sh ? ONCHIP : 21'h0);
          e = b21 ? e : {e[19:0] & m, 1'b0};
          ref_m[e] = x[15:0] ^ x[31:16];
          acc(1, ref_m[e]);
          acc(0, 16'h0000);
          chk(rd & dm, ref_m[e] & dm);
        end
        $display("config %0d wait code %0d done", i, c);
      end
    end
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
